// [host_bus.sv]
// Avalon-MM master standing in for the processor's segment-load logic
`timescale 1ns/10ps
module host_bus
	import sdd_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic [sdd_pkg::DATA_W-1:0]  avs_readdata,
	input  wire logic                        avs_waitrequest,
	output logic      [sdd_pkg::ADDR_W-1:0]  avs_address,
	output logic                             avs_read,
	output logic                             avs_write,
	output logic      [3:0]                  avs_byteenable,
	output logic      [sdd_pkg::DATA_W-1:0]  avs_writedata,
	output logic                             stuck
);
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = '0;
		stuck = 1'b0;
	end
	task automatic xfer(input logic rw, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_read <= !rw;
		avs_write <= rw;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest && n < 20);
		q = avs_readdata;
		if (avs_waitrequest)
			stuck <= 1'b1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines show garbage, not the last value
		avs_writedata <= ~d;
		avs_byteenable <= ~be;
		@(posedge sys_clk);
	endtask
endmodule

// [sdd_monitor.sv]
// Port-level checker for the segment descriptor decoder
`timescale 1ns/10ps
module sdd_monitor
	import sdd_pkg::*;
(
	input wire logic                        sys_clk,
	input wire logic                        arst_n,
	input wire logic [sdd_pkg::ADDR_W-1:0]  avs_address,
	input wire logic                        avs_write,
	input wire logic [3:0]                  avs_byteenable,
	input wire logic [sdd_pkg::DATA_W-1:0]  avs_writedata,
	input wire logic                        avs_waitrequest,
	input wire logic                        fault_pulse,
	input wire logic [7:0]                  fault_vector,
	input wire logic                        interrupt_enable_flag,
	input wire logic [15:0]                 task_pointer_register
);
	logic acc_w;
	logic cmd_w;
	logic dec_w;
	logic ent_w;
	logic flag_w;
	logic ptr_w;
	assign acc_w  = avs_write && !avs_waitrequest;
	// Lane 0 carries the command and flag bits, a masked write does nothing
	assign cmd_w  = acc_w && avs_address == OFF_CMD && avs_byteenable[0];
	assign dec_w  = cmd_w && avs_writedata[CMD_DECODE];
	assign ent_w  = cmd_w && avs_writedata[CMD_ENTER];
	assign flag_w = acc_w && avs_address == OFF_FLAGS && avs_byteenable[0];
	assign ptr_w  = acc_w && avs_address == OFF_TASK_PTR && |avs_byteenable[1:0];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	AST_PULSE_CAUSE: assert property (fault_pulse |-> $past(dec_w) || $past(dec_w, 2))
		else $error("fault pulse without a decode command");
	AST_PULSE_ONE: assert property (fault_pulse |=> !fault_pulse)
		else $error("fault pulse longer than one cycle");
	AST_PULSE_VEC: assert property (fault_pulse |-> ##[0:1] fault_vector != 8'h00)
		else $error("fault pulse with empty vector");
	AST_VEC_CODES: assert property (fault_vector inside {8'h00, 8'h0B, 8'h0D})
		else $error("fault vector outside the known codes");
	AST_VEC_CAUSE: assert property ($changed(fault_vector) |->
		$past(dec_w) || $past(dec_w, 2))
		else $error("fault vector moved without a decode");
	AST_IE_FALL: assert property ($fell(interrupt_enable_flag) |->
		$past(ent_w) || $past(ent_w, 2) || $past(flag_w))
		else $error("interrupt enable cleared without cause");
	AST_IE_RISE: assert property ($rose(interrupt_enable_flag) |-> $past(flag_w))
		else $error("interrupt enable set other than by a flags write");
	AST_TASK_CAUSE: assert property ($changed(task_pointer_register) |->
		$past(ent_w) || $past(ent_w, 2) || $past(ptr_w))
		else $error("task pointer moved without cause");
endmodule
bind segment_descriptor_decoder sdd_monitor u_sdd_monitor (.sys_clk, .arst_n, .avs_address,
	.avs_write, .avs_byteenable, .avs_writedata, .avs_waitrequest, .fault_pulse, .fault_vector,
	.interrupt_enable_flag, .task_pointer_register);

// [sdd_pkg.sv]
// Constants, field layout and types for the segment descriptor decoder
package sdd_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [5:0] OFF_DESC_LO   = 6'h00;
	localparam logic [5:0] OFF_DESC_HI   = 6'h04;
	localparam logic [5:0] OFF_CTX       = 6'h08;
	localparam logic [5:0] OFF_OFFSET    = 6'h0C;
	localparam logic [5:0] OFF_TARGET_HI = 6'h10;
	localparam logic [5:0] OFF_CMD       = 6'h14;
	localparam logic [5:0] OFF_RESULT    = 6'h18;
	localparam logic [5:0] OFF_BASE      = 6'h1C;
	localparam logic [5:0] OFF_LIMIT     = 6'h20;
	localparam logic [5:0] OFF_ENTRY_SEL = 6'h24;
	localparam logic [5:0] OFF_ENTRY_OFF = 6'h28;
	localparam logic [5:0] OFF_TASK_PTR  = 6'h2C;
	localparam logic [5:0] OFF_FLAGS     = 6'h30;
	localparam logic [5:0] OFF_STACK_TOP = 6'h34;

	// Descriptor high word fields
	localparam int HI_P      = 15;
	localparam int HI_DPL_LO = 13;
	localparam int HI_S      = 12;
	localparam int HI_TY_LO  = 8;
	localparam int HI_ACC    = 8;
	localparam int HI_DB     = 22;
	localparam int HI_G      = 23;
	localparam int WC_W      = 5;

	// Context, command and flag bits
	localparam int CTX_GLOBAL   = 0;
	localparam int CTX_PRIV_CHG = 1;
	localparam int CTX_STACK    = 2;
	localparam int CTX_WRITE    = 3;
	localparam int CTX_READ     = 4;
	localparam int CTX_EXEC     = 5;
	localparam int CMD_DECODE   = 0;
	localparam int CMD_ENTER    = 1;
	localparam int FLAG_IE      = 0;

	// System type codes
	localparam logic [3:0] TY_LTAB    = 4'h2;
	localparam logic [3:0] TY_TS16_AV = 4'h1;
	localparam logic [3:0] TY_TS16_BZ = 4'h3;
	localparam logic [3:0] TY_TS32_AV = 4'h9;
	localparam logic [3:0] TY_TS32_BZ = 4'hB;
	localparam logic [3:0] TY_CALL16  = 4'h4;
	localparam logic [3:0] TY_TASKG   = 4'h5;
	localparam logic [3:0] TY_INT16   = 4'h6;
	localparam logic [3:0] TY_TRAP16  = 4'h7;
	localparam logic [3:0] TY_CALL32  = 4'hC;
	localparam logic [3:0] TY_INT32   = 4'hE;
	localparam logic [3:0] TY_TRAP32  = 4'hF;

	localparam logic [7:0]  FAULT_NOT_PRESENT = 8'h0B;
	localparam logic [7:0]  FAULT_PROTECTION  = 8'h0D;
	localparam logic [31:0] WIDE_SP_TOP       = 32'h0FFFFFFF;
	localparam logic [31:0] NARROW_SP_TOP     = 32'h0000FFFF;
	localparam logic [11:0] PAGE_FILL         = 12'hFFF;
	localparam logic [31:0] RST_ZERO          = 32'h00000000;

	typedef enum logic [2:0] {
		GK_NONE,
		GK_CALL,
		GK_TASK,
		GK_INTR,
		GK_TRAP
	} gate_kind_t;

	typedef struct packed {
		logic [2:0] spare;
		logic [1:0] descriptor_privilege;
		logic       present;
		gate_kind_t gkind;
		logic       clears_ie;
		logic       task_busy;
		logic       local_table;
		logic       task_state;
		logic       gate;
		logic       big_stack;
		logic       writable;
		logic       expand_down;
		logic       readable;
		logic       conforming;
		logic       op32;
		logic       code;
		logic       system;
		logic       legacy;
		logic       fault;
		logic [7:0] fault_vec;
	} result_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [3:0]        byteenable;
		logic [DATA_W-1:0] writedata;
	} bus_req_t;
endpackage

// [segment_descriptor_decoder.sv]
// Segment descriptor attribute decoder and protection checker, Avalon-MM slave
`timescale 1ns/10ps
module segment_descriptor_decoder
	import sdd_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      arst_n,
	input  wire logic [sdd_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [3:0]                avs_byteenable,
	input  wire logic [sdd_pkg::DATA_W-1:0] avs_writedata,
	output logic      [sdd_pkg::DATA_W-1:0] avs_readdata,
	output logic                           avs_waitrequest,
	output logic                           fault_pulse,
	output logic      [7:0]                fault_vector,
	output logic                           interrupt_enable_flag,
	output logic      [15:0]               task_pointer_register
);
	import sdd_pkg::*;

	logic [31:0] desc_lo_r;
	logic [31:0] desc_hi_r;
	logic [31:0] ctx_r;
	logic [31:0] offset_r;
	logic [31:0] target_hi_r;
	result_t     result_r;
	logic [31:0] base_r;
	logic [31:0] limit_r;
	logic [31:0] entry_sel_r;
	logic [31:0] entry_off_r;
	logic [31:0] stack_top_r;
	logic [15:0] task_ptr_r;
	logic        ie_r;
	logic        done_r;
	logic [31:0] rdata_r;
	logic        fault_r;
	logic [7:0]  fvec_r;

	bus_req_t    req;
	logic        wr_go;
	logic        do_decode;
	logic        do_enter;

	result_t     res_nxt;
	logic [31:0] base_nxt;
	logic [31:0] limit_nxt;
	logic [31:0] esel_nxt;
	logic [31:0] eoff_nxt;
	logic [31:0] stop_nxt;
	logic [31:0] rd_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
					      input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic is_task_state(input logic [3:0] ty);
		return (ty == TY_TS16_AV) || (ty == TY_TS16_BZ) ||
		       (ty == TY_TS32_AV) || (ty == TY_TS32_BZ);
	endfunction

	// One wait cycle: read data is registered before the answering edge
	assign req.valid      = avs_read | avs_write;
	assign req.address    = avs_address;
	assign req.read       = avs_read;
	assign req.write      = avs_write;
	assign req.byteenable = avs_byteenable;
	assign req.writedata  = avs_writedata;
	assign avs_waitrequest = req.valid & ~done_r;
	assign wr_go     = req.write & done_r;
	assign do_decode = wr_go && (req.address == OFF_CMD) && req.byteenable[0] &&
			   req.writedata[CMD_DECODE];
	assign do_enter  = wr_go && (req.address == OFF_CMD) && req.byteenable[0] &&
			   req.writedata[CMD_ENTER] && !result_r.fault;

	assign avs_readdata          = rdata_r;
	assign fault_pulse           = fault_r;
	assign fault_vector          = fvec_r;
	assign interrupt_enable_flag = ie_r;
	assign task_pointer_register = task_ptr_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= req.valid & ~done_r;
		end
	end

	always_comb begin
		rd_nxt = RST_ZERO;
		if (req.address == OFF_DESC_LO) begin
			rd_nxt = desc_lo_r;
		end else if (req.address == OFF_DESC_HI) begin
			rd_nxt = desc_hi_r;
		end else if (req.address == OFF_CTX) begin
			rd_nxt = ctx_r;
		end else if (req.address == OFF_OFFSET) begin
			rd_nxt = offset_r;
		end else if (req.address == OFF_TARGET_HI) begin
			rd_nxt = target_hi_r;
		end else if (req.address == OFF_RESULT) begin
			rd_nxt = result_r;
		end else if (req.address == OFF_BASE) begin
			rd_nxt = base_r;
		end else if (req.address == OFF_LIMIT) begin
			rd_nxt = limit_r;
		end else if (req.address == OFF_ENTRY_SEL) begin
			rd_nxt = entry_sel_r;
		end else if (req.address == OFF_ENTRY_OFF) begin
			rd_nxt = entry_off_r;
		end else if (req.address == OFF_TASK_PTR) begin
			rd_nxt = {16'h0000, task_ptr_r};
		end else if (req.address == OFF_FLAGS) begin
			rd_nxt = {31'h00000000, ie_r};
		end else if (req.address == OFF_STACK_TOP) begin
			rd_nxt = stack_top_r;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= RST_ZERO;
		end else if (req.read && !done_r) begin
			rdata_r <= rd_nxt;
		end
	end

	// Decode of the held descriptor against the held context
	always_comb begin
		logic [3:0]  ty;
		logic [31:0] raw_lim;
		logic [31:0] eff_lim;
		logic        legacy;
		logic        bad;
		logic        np;
		logic [31:0] top;
		ty      = desc_hi_r[HI_TY_LO +: 4];
		legacy  = (desc_hi_r[31:16] == 16'h0000);
		raw_lim = 32'h00000000;
		eff_lim = 32'h00000000;
		bad     = 1'b0;
		np      = 1'b0;
		top     = NARROW_SP_TOP;
		res_nxt = '0;
		res_nxt.gkind = GK_NONE;
		base_nxt = RST_ZERO;
		esel_nxt = RST_ZERO;
		eoff_nxt = RST_ZERO;
		res_nxt.present = desc_hi_r[HI_P];
		res_nxt.descriptor_privilege     = desc_hi_r[HI_DPL_LO +: 2];
		res_nxt.system  = ~desc_hi_r[HI_S];
		np = ~desc_hi_r[HI_P];
		if (desc_hi_r[HI_S]) begin
			raw_lim  = {12'h000, desc_hi_r[19:16], desc_lo_r[15:0]};
			eff_lim  = desc_hi_r[HI_G] ? {raw_lim[19:0], PAGE_FILL} : raw_lim;
			base_nxt = {desc_hi_r[31:24], desc_hi_r[7:0], desc_lo_r[31:16]};
			res_nxt.code = ty[3];
			if (ty[3]) begin
				res_nxt.op32       = desc_hi_r[HI_DB];
				res_nxt.conforming = ty[2];
				res_nxt.readable   = ty[1];
				if (ctx_r[CTX_WRITE] || ctx_r[CTX_STACK]) begin
					bad = 1'b1;
				end
				if (ctx_r[CTX_READ] && !ty[1]) begin
					bad = 1'b1;
				end
				if (offset_r > eff_lim) begin
					bad = 1'b1;
				end
			end else begin
				res_nxt.expand_down = ty[2];
				res_nxt.writable    = ty[1];
				res_nxt.big_stack   = desc_hi_r[HI_DB];
				top = desc_hi_r[HI_DB] ? WIDE_SP_TOP : NARROW_SP_TOP;
				if ((ctx_r[CTX_WRITE] || ctx_r[CTX_STACK]) && !ty[1]) begin
					bad = 1'b1;
				end
				if (ctx_r[CTX_EXEC]) begin
					bad = 1'b1;
				end
				if (ty[2]) begin
					if (offset_r <= eff_lim || offset_r > top) begin
						bad = 1'b1;
					end
				end else if (offset_r > eff_lim) begin
					bad = 1'b1;
				end
			end
		end else begin
			res_nxt.legacy = legacy;
			if (legacy) begin
				base_nxt = {8'h00, desc_hi_r[7:0], desc_lo_r[31:16]};
				raw_lim  = {16'h0000, desc_lo_r[15:0]};
			end else begin
				base_nxt = {desc_hi_r[31:24], desc_hi_r[7:0], desc_lo_r[31:16]};
				raw_lim  = {12'h000, desc_hi_r[19:16], desc_lo_r[15:0]};
			end
			eff_lim = raw_lim;
			if (ty == TY_LTAB) begin
				res_nxt.local_table = 1'b1;
				res_nxt.descriptor_privilege = 2'b00;
				if (!ctx_r[CTX_GLOBAL]) begin
					bad = 1'b1;
				end
			end else if (is_task_state(ty)) begin
				res_nxt.task_state = 1'b1;
				res_nxt.task_busy  = ty[1];
				res_nxt.legacy     = ~ty[3];
			end else if (ty == TY_CALL16 || ty == TY_CALL32 || ty == TY_TASKG ||
				     ty == TY_INT16 || ty == TY_INT32 ||
				     ty == TY_TRAP16 || ty == TY_TRAP32) begin
				res_nxt.gate   = 1'b1;
				res_nxt.legacy = ~ty[3];
				base_nxt = RST_ZERO;
				eff_lim  = RST_ZERO;
				esel_nxt = {16'h0000, desc_lo_r[31:16]};
				if (ty == TY_TASKG) begin
					res_nxt.gkind = GK_TASK;
					res_nxt.legacy = 1'b0;
					eoff_nxt = RST_ZERO;
					if (target_hi_r[HI_S] || !is_task_state(target_hi_r[HI_TY_LO +: 4])) begin
						bad = 1'b1;
					end
				end else begin
					if (ty[2:0] == TY_CALL16[2:0]) begin
						res_nxt.gkind = GK_CALL;
					end else if (ty[2:0] == TY_INT16[2:0]) begin
						res_nxt.gkind = GK_INTR;
						res_nxt.clears_ie = 1'b1;
					end else begin
						res_nxt.gkind = GK_TRAP;
					end
					if (ty[3]) begin
						eoff_nxt = {desc_hi_r[31:16], desc_lo_r[15:0]};
					end else begin
						eoff_nxt = {16'h0000, desc_lo_r[15:0]};
					end
					if (!target_hi_r[HI_S] || !target_hi_r[HI_TY_LO + 3]) begin
						bad = 1'b1;
					end
				end
				// Word count kept in the low bits of the limit word for call gates with a privilege change
				if (res_nxt.gkind == GK_CALL && ctx_r[CTX_PRIV_CHG]) begin
					eff_lim = {27'h0000000, desc_hi_r[WC_W-1:0]};
				end
			end else begin
				bad = 1'b1;
			end
		end
		limit_nxt = eff_lim;
		stop_nxt  = top;
		// Not-present wins over other checks, it names the first failing condition
		if (np) begin
			res_nxt.fault     = 1'b1;
			res_nxt.fault_vec = FAULT_NOT_PRESENT;
		end else if (bad) begin
			res_nxt.fault     = 1'b1;
			res_nxt.fault_vec = FAULT_PROTECTION;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			result_r    <= '0;
			base_r      <= RST_ZERO;
			limit_r     <= RST_ZERO;
			entry_sel_r <= RST_ZERO;
			entry_off_r <= RST_ZERO;
			stack_top_r <= RST_ZERO;
		end else if (do_decode) begin
			result_r    <= res_nxt;
			base_r      <= base_nxt;
			limit_r     <= limit_nxt;
			entry_sel_r <= esel_nxt;
			entry_off_r <= eoff_nxt;
			stack_top_r <= stop_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_r <= 1'b0;
			fvec_r  <= 8'h00;
		end else begin
			fault_r <= do_decode & res_nxt.fault;
			if (do_decode) begin
				fvec_r <= res_nxt.fault_vec;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			desc_lo_r   <= RST_ZERO;
			ctx_r       <= RST_ZERO;
			offset_r    <= RST_ZERO;
			target_hi_r <= RST_ZERO;
		end else if (wr_go) begin
			if (req.address == OFF_DESC_LO) begin
				desc_lo_r <= merge(desc_lo_r, req.writedata, req.byteenable);
			end else if (req.address == OFF_CTX) begin
				ctx_r <= merge(ctx_r, req.writedata, req.byteenable);
			end else if (req.address == OFF_OFFSET) begin
				offset_r <= merge(offset_r, req.writedata, req.byteenable);
			end else if (req.address == OFF_TARGET_HI) begin
				target_hi_r <= merge(target_hi_r, req.writedata, req.byteenable);
			end
		end
	end

	// Code and data descriptors get their accessed flag marked by the decode
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			desc_hi_r <= RST_ZERO;
		end else if (wr_go && req.address == OFF_DESC_HI) begin
			desc_hi_r <= merge(desc_hi_r, req.writedata, req.byteenable);
		end else if (do_decode && desc_hi_r[HI_S]) begin
			desc_hi_r[HI_ACC] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			task_ptr_r <= 16'h0000;
		end else if (do_enter && result_r.gkind == GK_TASK) begin
			task_ptr_r <= entry_sel_r[15:0];
		end else if (wr_go && req.address == OFF_TASK_PTR) begin
			task_ptr_r <= 16'(merge({16'h0000, task_ptr_r}, req.writedata, req.byteenable));
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ie_r <= 1'b0;
		end else if (do_enter && result_r.clears_ie) begin
			ie_r <= 1'b0;
		end else if (wr_go && req.address == OFF_FLAGS && req.byteenable[0]) begin
			ie_r <= req.writedata[FLAG_IE];
		end
	end
endmodule

// [test_segment_descriptor_decoder.sv]
// Self-checking bench for the segment descriptor decoder
`timescale 1ns/10ps
module test_segment_descriptor_decoder;
	import sdd_pkg::*;
	logic               sys_clk;
	logic               arst_n;
	logic [ADDR_W-1:0]  avs_address;
	logic               avs_read;
	logic               avs_write;
	logic [3:0]         avs_byteenable;
	logic [DATA_W-1:0]  avs_writedata;
	logic [DATA_W-1:0]  avs_readdata;
	logic               avs_waitrequest;
	logic               fault_pulse;
	logic [7:0]         fault_vector;
	logic               interrupt_enable_flag;
	logic [15:0]        task_pointer_register;
	logic               stuck;
	logic [31:0]        res, v, hi, lo, sel, tg, w;
	logic [3:0]         t;
	logic               ok;
	logic [3:0]         gt [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
	logic [5:0]         zr [4] = '{OFF_RESULT, OFF_TASK_PTR, OFF_FLAGS, 6'h3C};
	int                 seed = 32'hAEF0FE5A;
	int                 fails = 0;
	int                 compares = 0;
	int                 pulses = 0;
	int                 p0 = 0;

	segment_descriptor_decoder u_segment_descriptor_decoder (.sys_clk, .arst_n, .avs_address,
		.avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .fault_pulse, .fault_vector, .interrupt_enable_flag,
		.task_pointer_register);
	host_bus u_host_bus (.sys_clk, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read,
		.avs_write, .avs_byteenable, .avs_writedata, .stuck);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_host_bus.xfer(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		u_host_bus.xfer(1'b0, a, 32'h0, 4'hF, q);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Pins of the last decode: one pulse exactly when it faulted
	task automatic pins(input logic [7:0] e);
		chk("fault pulse", e != 8'h00, pulses - p0);
		chk("fault vector", e, fault_vector);
	endtask
	task automatic dec(input logic [31:0] h, l, c, o, x);
		wr(OFF_DESC_LO, l);
		wr(OFF_DESC_HI, h);
		wr(OFF_CTX, c);
		wr(OFF_OFFSET, o);
		wr(OFF_TARGET_HI, x);
		p0 = pulses;
		wr(OFF_CMD, 32'h1);
		rd(OFF_RESULT, res);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [7:0] seg_fault(logic [31:0] h, l, c, o);
		logic [31:0] lim;
		logic [31:0] top;
		lim = {12'h000, h[19:16], l[15:0]};
		if (h[HI_G])
			lim = {lim[19:0], PAGE_FILL};
		top = h[HI_DB] ? WIDE_SP_TOP : NARROW_SP_TOP;
		if (!h[HI_P])
			return FAULT_NOT_PRESENT;
		if (h[11])
			return (c[CTX_WRITE] || c[CTX_STACK] || c[CTX_READ] && !h[9]) ? FAULT_PROTECTION : 8'h00;
		if (c[CTX_EXEC] || (c[CTX_WRITE] || c[CTX_STACK]) && !h[9])
			return FAULT_PROTECTION;
		if (h[10] ? (o <= lim || o > top) : o > lim)
			return FAULT_PROTECTION;
		return 8'h00;
	endfunction
	function automatic gate_kind_t gkind(logic [3:0] k);
		case (k)
			TY_CALL16, TY_CALL32: return GK_CALL;
			TY_TASKG: return GK_TASK;
			TY_INT16, TY_INT32: return GK_INTR;
			default: return GK_TRAP;
		endcase
	endfunction

	always @(posedge sys_clk) begin
		if (fault_pulse === 1'b1)
			pulses <= pulses + 1;
	end

	always @(posedge stuck) begin
		fails++;
		complete_run;
	end

	initial begin
		arst_n = 1'b0;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		wr(6'h3C, 32'hFFFFFFFF);
		foreach (zr[i]) begin
			rd(zr[i], v);
			chk("reset or unmapped", 32'h0, v);
		end
		wr(OFF_FLAGS, 32'h1);
		u_host_bus.xfer(1'b1, OFF_FLAGS, 32'h0, 4'hE, v);
		rd(OFF_FLAGS, v);
		chk("masked lane", 32'h1, v);
		for (int i = 0; i < 80; i++) begin
			ok = i[0];
			v = $random(seed);
			hi = ok ? ((v & 32'h00406600) | 32'h00009800) : ((v & 32'h00CFE600) | 32'h00001000);
			lo = $random(seed);
			tg = $random(seed) & 32'h3C;
			sel = ok ? 32'h0 : ($random(seed) & 32'h000FFFFF);
			dec(hi, lo, tg, sel, 32'h0);
			v = seg_fault(hi, lo, tg, sel);
			chk("seg fault", {v[7:0] != 8'h00, v[7:0]}, res[8:0]);
			pins(v[7:0]);
			if (hi[HI_P]) begin
				v = {hi[14:13], hi[9], hi[10], hi[22], 1'b1};
				if (!ok)
					v = {hi[14:13], hi[22], hi[9], hi[10], 1'b0};
				w = ok ? {res[28:27], res[14:11]} : {res[28:27], res[17:15], res[11]};
				chk("seg attr", v, w);
				rd(OFF_DESC_HI, v);
				chk("accessed", hi | 32'h100, v);
				if (!ok) begin
					rd(OFF_STACK_TOP, v);
					chk("stack top", hi[HI_DB] ? WIDE_SP_TOP : NARROW_SP_TOP, v);
					rd(OFF_LIMIT, v);
					w = hi[HI_G] ? {hi[19:16], lo[15:0], PAGE_FILL} : {12'h000, hi[19:16], lo[15:0]};
					chk("seg limit", w, v);
				end
			end
		end
		for (int i = 0; i < 7; i++) begin
			t = gt[i];
			sel = $random(seed) & 32'hFFFF;
			hi = {16'hA5C3, 4'h8, t, 8'h07};
			lo = {sel[15:0], 16'h4567};
			tg = (t == TY_TASKG) ? 32'h00008900 : 32'h00009800;
			dec(hi & 32'hFFFF7FFF, lo, 32'h3, 32'h0, tg);
			chk("absent gate", FAULT_NOT_PRESENT, res[7:0]);
			pins(FAULT_NOT_PRESENT);
			dec(hi, lo, 32'h3, 32'h0, tg ^ 32'h00001100);
			chk("gate target", FAULT_PROTECTION, res[7:0]);
			pins(FAULT_PROTECTION);
			// Privilege change only on the first four gate types, so one call gate sees none
			dec(hi, lo, i < 4 ? 32'h3 : 32'h1, 32'h0, tg);
			ok = t == TY_INT16 || t == TY_INT32;
			w = {gkind(t), ok, 2'b11, 9'h000};
			chk("gate kind", w, {res[25:22], res[18], res[10], res[8:0]});
			pins(8'h00);
			rd(OFF_ENTRY_SEL, v);
			chk("entry sel", sel, v);
			rd(OFF_ENTRY_OFF, v);
			w = t[3] ? 32'hA5C34567 : 32'h00004567;
			chk("entry off", t == TY_TASKG ? 32'h0 : w, v);
			rd(OFF_LIMIT, v);
			w = ((t == TY_CALL16 || t == TY_CALL32) && i < 4) ? 32'h7 : 32'h0;
			chk("word count", w, v);
			wr(OFF_FLAGS, 32'h1);
			wr(OFF_CMD, 32'h2);
			@(posedge sys_clk);
			chk("int enable", !ok, interrupt_enable_flag);
			if (t == TY_TASKG)
				chk("task ptr", sel, task_pointer_register);
		end
		for (int i = 0; i < 16; i++) begin
			t = i[3:0];
			dec({16'h0012, 4'h8, t, 8'h00}, 32'h0, 32'h1, 32'h0, 32'h0);
			ok = (t == TY_LTAB) || (!t[2] && t[0]);
			chk("sys fault", ok ? 8'h00 : FAULT_PROTECTION, res[7:0]);
			pins(ok ? 8'h00 : FAULT_PROTECTION);
			if (ok && t != TY_LTAB)
				chk("task state", {t[1], 1'b1}, {res[21], res[19]});
		end
		dec(32'h0000E25A, 32'hBEEF0010, 32'h0, 32'h0, 32'h0);
		chk("local outside", FAULT_PROTECTION, res[7:0]);
		dec(32'h0000E25A, 32'hBEEF0010, 32'h1, 32'h0, 32'h0);
		chk("local legacy", {4'b0011, 9'h000}, {res[28:27], res[20], res[9], res[8:0]});
		rd(OFF_BASE, v);
		chk("legacy base", 32'h005ABEEF, v);
		dec(32'h7703E25A, 32'hBEEF0010, 32'h1, 32'h0, 32'h0);
		chk("current format", 1'b0, res[9]);
		rd(OFF_BASE, v);
		chk("current base", 32'h775ABEEF, v);
		rd(OFF_LIMIT, v);
		chk("current limit", 32'h00030010, v);
		complete_run;
	end
endmodule
